//--- inc/alu_pkg.sv
// Shared constants and types for the compact-encoding integer datapath.
package alu_pkg;

  localparam int DATA_W       = 64;
  localparam int WORD_W       = 32;
  localparam int IDX_W        = 5;
  localparam int IMM_W        = 8;
  localparam int IMM4_W       = 4;
  localparam int IMM5_W       = 5;
  localparam int SP_ADJ_SHIFT = 3;
  localparam int ADDR_SHIFT   = 2;

  localparam logic [IDX_W-1:0]  T_REG_INDEX  = 5'h18;
  localparam logic [IDX_W-1:0]  SP_REG_INDEX = 5'h1D;
  localparam logic [DATA_W-1:0] DATA_RST     = 64'h0;

  typedef enum logic [4:0] {
    load_immediate_op               = 5'h00,
    add_imm_unsigned_op_3           = 5'h01,
    add_imm_unsigned_op_2           = 5'h02,
    add_imm_unsigned_op_sp          = 5'h03,
    add_imm_unsigned_op_pc          = 5'h04,
    add_imm_unsigned_op_sprel       = 5'h05,
    dword_add_imm_unsigned_op_3     = 5'h06,
    dword_add_imm_unsigned_op_2     = 5'h07,
    dword_add_imm_unsigned_op_sp    = 5'h08,
    dword_add_imm_unsigned_op_pc    = 5'h09,
    dword_add_imm_unsigned_op_sprel = 5'h0A,
    set_less_imm_op                 = 5'h0B,
    set_less_imm_unsigned_op        = 5'h0C,
    compare_imm_op                  = 5'h0D,
    add_unsigned_op                 = 5'h0E,
    sub_unsigned_op                 = 5'h0F,
    dword_add_unsigned_op           = 5'h10,
    dword_sub_unsigned_op           = 5'h11,
    set_less_op                     = 5'h12,
    set_less_unsigned_op            = 5'h13,
    compare_reg_op                  = 5'h14,
    negate_op                       = 5'h15,
    and_op                          = 5'h16,
    or_op                           = 5'h17,
    xor_op                          = 5'h18,
    not_op                          = 5'h19,
    move_to_compact_op              = 5'h1A,
    move_to_full_op                 = 5'h1B
  } alu_op_t;

  typedef enum logic [3:0] {
    res_pass        = 4'h0,
    res_sum_word    = 4'h1,
    res_sum_dword   = 4'h2,
    res_lt_signed   = 4'h3,
    res_lt_unsigned = 4'h4,
    res_xor         = 4'h5,
    res_and         = 4'h6,
    res_or          = 4'h7,
    res_not         = 4'h8
  } res_kind_t;

  typedef struct packed {
    alu_op_t           op;
    logic [DATA_W-1:0] src_a;
    logic [DATA_W-1:0] src_b;
    logic [IMM_W-1:0]  imm;
    logic [DATA_W-1:0] instruction_base_address;
    logic [DATA_W-1:0] stack_pointer;
    logic [IDX_W-1:0]  idx_x;
    logic [IDX_W-1:0]  idx_y;
    logic [IDX_W-1:0]  idx_z;
    logic [IDX_W-1:0]  full_register_selector;
  } alu_req_t;

  typedef struct packed {
    logic              wr_en;
    logic [IDX_W-1:0]  idx;
    logic [DATA_W-1:0] data;
  } alu_wb_t;

endpackage : alu_pkg

//--- core/alu_addsub.sv
// Adder and subtractor with signed and unsigned less-than flags.
`timescale 1ns/10ps
module alu_addsub #(
  parameter int W = 64
) (
  input  wire logic [W-1:0] a,
  input  wire logic [W-1:0] b,
  input  wire logic         sub,
  output logic      [W-1:0] sum,
  output logic              lt_signed,
  output logic              lt_unsigned
);

  logic [W:0] full;

  initial begin
    if (W < 2) begin
      $error("alu_addsub needs a width of at least 2.");
    end
  end

  // Subtraction adds the complement plus one; the carry out is the inverse borrow.
  assign full = {1'b0, a} + {1'b0, (sub ? ~b : b)} + {{W{1'b0}}, sub};
  assign sum  = full[W-1:0];
  // A sign mismatch decides directly, so the flag stays right when the difference overflows.
  assign lt_signed   = (a[W-1] ^ b[W-1]) ? a[W-1] : full[W-1];
  assign lt_unsigned = ~full[W];

endmodule : alu_addsub

//--- core/compact_isa_integer_alu.sv
// Integer execution datapath for the compact 16-bit instruction encoding.
// Operation
// RULE1 - Load immediate zero-extends 8-bit immediate into destination register.
// RULE2 - Three-operand add immediate: sign-extend 4-bit immediate, add, write 32-bit sum.
// RULE3 - Two-operand add immediate: sign-extend 8-bit immediate, add, write back same register.
// RULE4 - Stack adjust: 8-bit immediate shifted left three, sign-extended, added to stack.
// RULE5 - PC-relative: masked base address plus 8-bit immediate shifted left two.
// RULE6 - Stack-relative: 8-bit immediate shifted left two plus stack pointer.
// RULE7 - Doubleword three-operand add: 4-bit immediate sign-extended to 64 bits.
// RULE8 - Doubleword two-operand add: 5-bit immediate sign-extended, written back same register.
// RULE9 - Doubleword stack adjust: 8-bit immediate shifted three, sign-extended, 64-bit sum.
// RULE10 - Doubleword PC-relative: masked base plus 5-bit immediate shifted left two.
// RULE11 - Doubleword stack-relative: 5-bit immediate shifted left two plus stack pointer.
// RULE12 - Doubleword operations only in 64-bit or kernel mode, else reserved exception.
// RULE13 - Unsigned add and subtract never raise an integer overflow exception.
// RULE14 - Set-less-than immediate compares against zero-extended immediate into compare register.
// RULE15 - Compare immediate XORs zero-extended immediate with register into compare register.
// RULE16 - Word add and subtract of two registers into third register.
// RULE17 - Doubleword add and subtract of two registers into third register.
// RULE18 - Register set-less-than, signed or unsigned, correct despite overflow, no exception.
// RULE19 - Register compare XORs two registers into the compare register.
// RULE20 - Negate subtracts source from zero, 32-bit result to destination.
// RULE21 - AND and XOR combine into first register; invert complements source.
// RULE22 - Moves copy between compact and any of 32 registers unchanged.
// RULE23 - OR combines destination register with source register bit by bit.
`timescale 1ns/10ps
module compact_isa_integer_alu
  import alu_pkg::*;
#(
  parameter int              DW       = DATA_W,
  parameter logic [IDX_W-1:0] SP_INDEX = SP_REG_INDEX,
  parameter logic [IDX_W-1:0] T_INDEX  = T_REG_INDEX
) (
  input  wire logic     clock,
  input  wire logic     rst_n,
  input  wire logic     req_valid,
  input  wire alu_req_t req,
  input  wire logic     mode_64,
  input  wire logic     kernel_mode,
  output alu_wb_t       wb,
  output logic          rsvd_instr_exc,
  output logic          int_overflow_exc
);

  initial begin
    if (DW != DATA_W) begin
      $error("compact_isa_integer_alu supports only a 64-bit datapath.");
    end
  end

  logic [DATA_W-1:0] sext4;
  logic [DATA_W-1:0] sext5;
  logic [DATA_W-1:0] sext8;
  logic [DATA_W-1:0] zext8;
  logic [DATA_W-1:0] sp_adj;
  logic [DATA_W-1:0] off8_w;
  logic [DATA_W-1:0] off5_w;
  logic [DATA_W-1:0] base_masked;

  logic [DATA_W-1:0] add_a;
  logic [DATA_W-1:0] add_b;
  logic              add_sub;
  logic [DATA_W-1:0] logic_b;
  logic [DATA_W-1:0] pass_val;
  res_kind_t         kind;

  logic [DATA_W-1:0] sum;
  logic              lt_s;
  logic              lt_u;

  logic [DATA_W-1:0] result;
  logic [IDX_W-1:0]  dst_idx;
  logic              known_op;
  logic              dword_op;
  logic              rsvd;

  alu_wb_t           wb_ff;
  alu_wb_t           nxt_wb;
  logic              rsvd_ff;

  // Immediate forms.
  always_comb begin
    sext4 = {{(DATA_W-IMM4_W){req.imm[IMM4_W-1]}}, req.imm[IMM4_W-1:0]};
    sext5 = {{(DATA_W-IMM5_W){req.imm[IMM5_W-1]}}, req.imm[IMM5_W-1:0]};
    sext8 = {{(DATA_W-IMM_W){req.imm[IMM_W-1]}}, req.imm};
    zext8 = {{(DATA_W-IMM_W){1'b0}}, req.imm};
    sp_adj = {{(DATA_W-IMM_W-SP_ADJ_SHIFT){req.imm[IMM_W-1]}}, req.imm,
              {SP_ADJ_SHIFT{1'b0}}};
    off8_w = {{(DATA_W-IMM_W-ADDR_SHIFT){1'b0}}, req.imm, {ADDR_SHIFT{1'b0}}};
    off5_w = {{(DATA_W-IMM5_W-ADDR_SHIFT){1'b0}}, req.imm[IMM5_W-1:0],
              {ADDR_SHIFT{1'b0}}};
    base_masked = {req.instruction_base_address[DATA_W-1:ADDR_SHIFT],
                   {ADDR_SHIFT{1'b0}}};
  end

  // Operand selection and result kind.
  always_comb begin
    add_a    = DATA_RST;
    add_b    = DATA_RST;
    add_sub  = 1'b0;
    logic_b  = req.src_b;
    pass_val = req.src_a;
    kind     = res_pass;
    case (req.op)
      load_immediate_op: begin
        pass_val = zext8; // RULE1
      end
      add_imm_unsigned_op_3: begin
        add_a = req.src_a;
        add_b = sext4; // RULE2
        kind  = res_sum_word;
      end
      add_imm_unsigned_op_2: begin
        add_a = req.src_a;
        add_b = sext8; // RULE3
        kind  = res_sum_word;
      end
      add_imm_unsigned_op_sp: begin
        add_a = req.stack_pointer;
        add_b = sp_adj; // RULE4
        kind  = res_sum_word;
      end
      add_imm_unsigned_op_pc: begin
        add_a = base_masked;
        add_b = off8_w; // RULE5
        kind  = res_sum_word;
      end
      add_imm_unsigned_op_sprel: begin
        add_a = req.stack_pointer;
        add_b = off8_w; // RULE6
        kind  = res_sum_word;
      end
      dword_add_imm_unsigned_op_3: begin
        add_a = req.src_a;
        add_b = sext4; // RULE7
        kind  = res_sum_dword;
      end
      dword_add_imm_unsigned_op_2: begin
        add_a = req.src_a;
        add_b = sext5; // RULE8
        kind  = res_sum_dword;
      end
      dword_add_imm_unsigned_op_sp: begin
        add_a = req.stack_pointer;
        add_b = sp_adj; // RULE9
        kind  = res_sum_dword;
      end
      dword_add_imm_unsigned_op_pc: begin
        add_a = base_masked;
        add_b = off5_w; // RULE10
        kind  = res_sum_dword;
      end
      dword_add_imm_unsigned_op_sprel: begin
        add_a = req.stack_pointer;
        add_b = off5_w; // RULE11
        kind  = res_sum_dword;
      end
      set_less_imm_op: begin
        add_a   = req.src_a;
        add_b   = zext8;
        add_sub = 1'b1;
        kind    = res_lt_signed; // RULE14
      end
      set_less_imm_unsigned_op: begin
        add_a   = req.src_a;
        add_b   = zext8;
        add_sub = 1'b1;
        kind    = res_lt_unsigned; // RULE14
      end
      compare_imm_op: begin
        logic_b = zext8;
        kind    = res_xor; // RULE15
      end
      add_unsigned_op: begin
        add_a = req.src_a;
        add_b = req.src_b;
        kind  = res_sum_word; // RULE16
      end
      sub_unsigned_op: begin
        add_a   = req.src_a;
        add_b   = req.src_b;
        add_sub = 1'b1;
        kind    = res_sum_word; // RULE16
      end
      dword_add_unsigned_op: begin
        add_a = req.src_a;
        add_b = req.src_b;
        kind  = res_sum_dword; // RULE17
      end
      dword_sub_unsigned_op: begin
        add_a   = req.src_a;
        add_b   = req.src_b;
        add_sub = 1'b1;
        kind    = res_sum_dword; // RULE17
      end
      set_less_op: begin
        add_a   = req.src_a;
        add_b   = req.src_b;
        add_sub = 1'b1;
        kind    = res_lt_signed; // RULE18
      end
      set_less_unsigned_op: begin
        add_a   = req.src_a;
        add_b   = req.src_b;
        add_sub = 1'b1;
        kind    = res_lt_unsigned; // RULE18
      end
      compare_reg_op: begin
        kind = res_xor; // RULE19
      end
      negate_op: begin
        add_a   = DATA_RST;
        add_b   = req.src_b;
        add_sub = 1'b1;
        kind    = res_sum_word; // RULE20
      end
      and_op: begin
        kind = res_and; // RULE21
      end
      or_op: begin
        kind = res_or; // RULE23
      end
      xor_op: begin
        kind = res_xor; // RULE21
      end
      not_op: begin
        kind = res_not; // RULE21
      end
      move_to_compact_op, move_to_full_op: begin
        pass_val = req.src_a; // RULE22
      end
      default: begin
        kind = res_pass;
      end
    endcase
  end

  alu_addsub #(
    .W (DATA_W)
  ) u_addsub (
    .a           (add_a),
    .b           (add_b),
    .sub         (add_sub),
    .sum         (sum),
    .lt_signed   (lt_s),
    .lt_unsigned (lt_u)
  );

  // Result formation; word results are sign-extended from bit 31.
  always_comb begin
    case (kind)
      res_sum_word:    result = {{(DATA_W-WORD_W){sum[WORD_W-1]}}, sum[WORD_W-1:0]};
      res_sum_dword:   result = sum;
      res_lt_signed:   result = {{(DATA_W-1){1'b0}}, lt_s}; // RULE18
      res_lt_unsigned: result = {{(DATA_W-1){1'b0}}, lt_u}; // RULE18
      res_xor:         result = req.src_a ^ logic_b;
      res_and:         result = req.src_a & req.src_b;
      res_or:          result = req.src_a | req.src_b; // RULE23
      res_not:         result = ~req.src_b;
      res_pass:        result = pass_val;
      default:         result = DATA_RST;
    endcase
  end

  // Destination register selection.
  always_comb begin
    known_op = 1'b1;
    case (req.op)
      load_immediate_op:               dst_idx = req.idx_x;
      add_imm_unsigned_op_3:           dst_idx = req.idx_y;
      add_imm_unsigned_op_2:           dst_idx = req.idx_x; // RULE3
      add_imm_unsigned_op_sp:          dst_idx = SP_INDEX; // RULE4
      add_imm_unsigned_op_pc:          dst_idx = req.idx_x;
      add_imm_unsigned_op_sprel:       dst_idx = req.idx_x;
      dword_add_imm_unsigned_op_3:     dst_idx = req.idx_y;
      dword_add_imm_unsigned_op_2:     dst_idx = req.idx_y; // RULE8
      dword_add_imm_unsigned_op_sp:    dst_idx = SP_INDEX; // RULE9
      dword_add_imm_unsigned_op_pc:    dst_idx = req.idx_y;
      dword_add_imm_unsigned_op_sprel: dst_idx = req.idx_y;
      set_less_imm_op:                 dst_idx = T_INDEX; // RULE14
      set_less_imm_unsigned_op:        dst_idx = T_INDEX; // RULE14
      compare_imm_op:                  dst_idx = T_INDEX; // RULE15
      add_unsigned_op:                 dst_idx = req.idx_z; // RULE16
      sub_unsigned_op:                 dst_idx = req.idx_z; // RULE16
      dword_add_unsigned_op:           dst_idx = req.idx_z; // RULE17
      dword_sub_unsigned_op:           dst_idx = req.idx_z; // RULE17
      set_less_op:                     dst_idx = T_INDEX; // RULE18
      set_less_unsigned_op:            dst_idx = T_INDEX; // RULE18
      compare_reg_op:                  dst_idx = T_INDEX; // RULE19
      negate_op:                       dst_idx = req.idx_x; // RULE20
      and_op:                          dst_idx = req.idx_x; // RULE21
      or_op:                           dst_idx = req.idx_x; // RULE23
      xor_op:                          dst_idx = req.idx_x; // RULE21
      not_op:                          dst_idx = req.idx_x; // RULE21
      move_to_compact_op:              dst_idx = req.idx_y; // RULE22
      move_to_full_op:                 dst_idx = req.full_register_selector; // RULE22
      default: begin
        dst_idx  = {IDX_W{1'b0}};
        known_op = 1'b0;
      end
    endcase
  end

  // Doubleword classification.
  always_comb begin
    case (req.op)
      dword_add_imm_unsigned_op_3,
      dword_add_imm_unsigned_op_2,
      dword_add_imm_unsigned_op_sp,
      dword_add_imm_unsigned_op_pc,
      dword_add_imm_unsigned_op_sprel,
      dword_add_unsigned_op,
      dword_sub_unsigned_op: dword_op = 1'b1;
      default:               dword_op = 1'b0;
    endcase
  end

  // A doubleword request in neither 64-bit nor kernel mode writes nothing.
  assign rsvd = req_valid && dword_op && !(mode_64 || kernel_mode); // RULE12

  always_comb begin
    nxt_wb.wr_en = req_valid && known_op && !rsvd; // RULE12
    nxt_wb.idx   = dst_idx;
    nxt_wb.data  = result;
  end

  // Write-back stage register.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wb_ff <= '0;
    end else begin
      wb_ff <= nxt_wb;
    end
  end

  // Reserved-instruction request to the exception unit.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rsvd_ff <= 1'b0;
    end else begin
      rsvd_ff <= rsvd; // RULE12
    end
  end

  assign wb               = wb_ff;
  assign rsvd_instr_exc   = rsvd_ff;
  // No operation of this block traps on overflow.
  assign int_overflow_exc = 1'b0; // RULE13

endmodule : compact_isa_integer_alu

//--- test/regfile_model.sv
// Register file and exception unit model on the result side.
`timescale 1ns/10ps
module regfile_model
  import alu_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire alu_wb_t    wb,
  input  wire logic       rsvd_instr_exc,
  output logic      [7:0] exc_count
);
  logic [DATA_W-1:0] gpr_ff [32];
  logic [7:0]        exc_count_ff;

  always_ff @(posedge clock) begin
    if (wb.wr_en) begin
      gpr_ff[wb.idx] <= wb.data;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      exc_count_ff <= 8'h00;
    end else if (rsvd_instr_exc) begin
      exc_count_ff <= exc_count_ff + 8'h01;
    end
  end

  assign exc_count = exc_count_ff;
endmodule : regfile_model

//--- test/alu_chk.sv
// Port checker for the compact integer datapath.
`timescale 1ns/10ps
module alu_chk
  import alu_pkg::*;
#(
  parameter int               DW       = DATA_W,
  parameter logic [IDX_W-1:0] SP_INDEX = SP_REG_INDEX,
  parameter logic [IDX_W-1:0] T_INDEX  = T_REG_INDEX
) (
  input wire logic     clock,
  input wire logic     rst_n,
  input wire logic     req_valid,
  input wire alu_req_t req,
  input wire logic     mode_64,
  input wire logic     kernel_mode,
  input wire alu_wb_t  wb,
  input wire logic     rsvd_instr_exc,
  input wire logic     int_overflow_exc
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_take(alu_op_t o);
    req_valid && req.op == o;
  endsequence

  sequence s_dword;
    req_valid && req.op inside {[dword_add_imm_unsigned_op_3:dword_add_imm_unsigned_op_sprel],
                                dword_add_unsigned_op, dword_sub_unsigned_op};
  endsequence

  chk_no_overflow: assert property (int_overflow_exc == 1'b0)
    else $error("overflow flag raised");
  chk_load_imm: assert property (s_take(load_immediate_op) |=> wb.wr_en
    && wb.idx == $past(req.idx_x) && wb.data == {56'h0, $past(req.imm)})
    else $error("load immediate result wrong");
  chk_dword_refused: assert property (s_dword ##0 (!mode_64 && !kernel_mode)
    |=> rsvd_instr_exc && !wb.wr_en)
    else $error("doubleword op not refused");
  chk_dword_allowed: assert property (s_dword ##0 (mode_64 || kernel_mode)
    |=> wb.wr_en && !rsvd_instr_exc)
    else $error("doubleword op not executed");
  chk_sp_adjust: assert property (s_take(add_imm_unsigned_op_sp) |=> wb.idx == SP_INDEX)
    else $error("stack adjust target wrong");
  chk_dword_add: assert property (s_take(dword_add_unsigned_op) ##0 mode_64
    |=> wb.data == $past(req.src_a) + $past(req.src_b))
    else $error("doubleword sum wrong");
  chk_slt_signed: assert property (s_take(set_less_op) |=> wb.idx == T_INDEX
    && wb.data == {63'h0, $signed($past(req.src_a)) < $signed($past(req.src_b))})
    else $error("signed less-than wrong");
  chk_cmp_reg: assert property (s_take(compare_reg_op) |=> wb.idx == T_INDEX
    && wb.data == ($past(req.src_a) ^ $past(req.src_b)))
    else $error("register compare wrong");
  chk_move_full: assert property (s_take(move_to_full_op)
    |=> wb.idx == $past(req.full_register_selector) && wb.data == $past(req.src_a))
    else $error("move to full register wrong");
endmodule : alu_chk

bind compact_isa_integer_alu alu_chk #(.DW(DW), .SP_INDEX(SP_INDEX), .T_INDEX(T_INDEX)) u_chk (
  .clock(clock), .rst_n(rst_n), .req_valid(req_valid), .req(req), .mode_64(mode_64),
  .kernel_mode(kernel_mode), .wb(wb), .rsvd_instr_exc(rsvd_instr_exc),
  .int_overflow_exc(int_overflow_exc));

//--- test/compact_isa_integer_alu_tb.sv
// Self-checking bench for the compact integer datapath.
`timescale 1ns/10ps
module compact_isa_integer_alu_tb
  import alu_pkg::*;
;
  logic       clock;
  logic       rst_n;
  logic       req_valid;
  alu_req_t   req;
  logic       m64;
  logic       kern;
  alu_wb_t    wb;
  logic       rsvd;
  logic       ovf;
  logic [7:0] exc_count;
  int         bad_count;
  int         comparisons;

  compact_isa_integer_alu DUT (.clock(clock), .rst_n(rst_n), .req_valid(req_valid), .req(req),
    .mode_64(m64), .kernel_mode(kern), .wb(wb), .rsvd_instr_exc(rsvd), .int_overflow_exc(ovf));
  regfile_model PART (.clock(clock), .rst_n(rst_n), .wb(wb), .rsvd_instr_exc(rsvd),
    .exc_count(exc_count));

  task automatic chk64(input string n, input logic [63:0] e, input logic [63:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk64

  task automatic op(input alu_op_t o, input logic [63:0] a, input logic [63:0] b,
                    input logic [7:0] im, input logic [4:0] ei, input logic [63:0] ed,
                    input logic ew = 1'b1, input logic er = 1'b0);
    @(posedge clock);
    req_valid <= 1'b1;
    req       <= '{o, a, b, im, a, a, 5'h01, 5'h02, 5'h03, 5'h1F};
    @(posedge clock);
    req_valid <= 1'b0;
    #1;
    chk64("wr_en", {63'h0, ew}, {63'h0, wb.wr_en});
    chk64("rsvd", {63'h0, er}, {63'h0, rsvd});
    chk64("overflow", 64'h0, {63'h0, ovf});
    if (ew) begin
      chk64("idx", {59'h0, ei}, {59'h0, wb.idx});
      chk64("data", ed, wb.data);
    end
  endtask : op

  task automatic done(input string n);
    $display("test %s complete", n);
  endtask : done

  task automatic t_reset();
    #1;
    chk64("reset data", 64'h0, wb.data);
    @(posedge clock);
    #1;
    chk64("reset wr_en", 64'h0, {63'h0, wb.wr_en});
    done("reset");
  endtask : t_reset

  task automatic t_word_imm();
    op(load_immediate_op, 64'hFFFF, 64'h0, 8'hFF, 5'h01, 64'hFF);
    op(add_imm_unsigned_op_3, 64'h7FFFFFFF, 64'h0, 8'hF1, 5'h02, 64'hFFFFFFFF80000000);
    op(add_imm_unsigned_op_2, 64'h100, 64'h0, 8'h80, 5'h01, 64'h80);
    op(add_imm_unsigned_op_sp, 64'h1000, 64'h0, 8'hFF, 5'h1D, 64'hFF8);
    op(add_imm_unsigned_op_pc, 64'h1003, 64'h0, 8'h40, 5'h01, 64'h1100);
    op(add_imm_unsigned_op_sprel, 64'h2000, 64'h0, 8'hFF, 5'h01, 64'h23FC);
    done("word_imm");
  endtask : t_word_imm

  task automatic t_modes();
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      m64  <= i[1];
      kern <= i[0];
      op(dword_add_unsigned_op, 64'h5, 64'h7, 8'h0, 5'h03, 64'hC, i != 0, i == 0);
    end
    chk64("exc count", 64'h1, {56'h0, exc_count});
    op(alu_op_t'(5'h1C), 64'h5, 64'h7, 8'h0, 5'h03, 64'h0, 1'b0, 1'b0);
    done("modes");
  endtask : t_modes

  task automatic t_dword_imm();
    op(dword_add_imm_unsigned_op_3, 64'h100000000, 64'h0, 8'h08, 5'h02, 64'hFFFFFFF8);
    op(dword_add_imm_unsigned_op_2, 64'h0, 64'h0, 8'hF0, 5'h02, 64'hFFFFFFFFFFFFFFF0);
    op(dword_add_imm_unsigned_op_sp, 64'h100000000, 64'h0, 8'h80, 5'h1D, 64'hFFFFFC00);
    op(dword_add_imm_unsigned_op_pc, 64'h100000007, 64'h0, 8'hFF, 5'h02, 64'h100000080);
    op(dword_add_imm_unsigned_op_sprel, 64'h100000000, 64'h0, 8'hFF, 5'h02, 64'h10000007C);
    done("dword_imm");
  endtask : t_dword_imm

  task automatic t_compare();
    op(set_less_imm_op, 64'hFFFFFFFFFFFFFFFF, 64'h0, 8'h05, 5'h18, 64'h1);
    op(set_less_imm_unsigned_op, 64'hFFFFFFFFFFFFFFFF, 64'h0, 8'h05, 5'h18, 64'h0);
    op(compare_imm_op, 64'h1234, 64'h0, 8'hFF, 5'h18, 64'h12CB);
    op(set_less_op, 64'h8000000000000000, 64'h1, 8'h0, 5'h18, 64'h1);
    op(set_less_unsigned_op, 64'h8000000000000000, 64'h1, 8'h0, 5'h18, 64'h0);
    op(compare_reg_op, 64'hF0F0, 64'h0FF0, 8'h0, 5'h18, 64'hFF00);
    done("compare");
  endtask : t_compare

  task automatic t_reg();
    op(add_unsigned_op, 64'hFFFFFFFF, 64'h1, 8'h0, 5'h03, 64'h0);
    op(sub_unsigned_op, 64'h0, 64'h1, 8'h0, 5'h03, 64'hFFFFFFFFFFFFFFFF);
    op(dword_add_unsigned_op, 64'hFFFFFFFF, 64'h1, 8'h0, 5'h03, 64'h100000000);
    op(dword_sub_unsigned_op, 64'h0, 64'h1, 8'h0, 5'h03, 64'hFFFFFFFFFFFFFFFF);
    op(negate_op, 64'h5, 64'h80000000, 8'h0, 5'h01, 64'hFFFFFFFF80000000);
    op(and_op, 64'hFF00, 64'h0FF0, 8'h0, 5'h01, 64'h0F00);
    op(xor_op, 64'hFF00, 64'h0FF0, 8'h0, 5'h01, 64'hF0F0);
    op(or_op, 64'hFF00, 64'h0FF0, 8'h0, 5'h01, 64'hFFF0);
    op(not_op, 64'hFF00, 64'h0FF0, 8'h0, 5'h01, 64'hFFFFFFFFFFFFF00F);
    op(move_to_compact_op, 64'hDEADBEEF01234567, 64'h0, 8'h0, 5'h02, 64'hDEADBEEF01234567);
    op(move_to_full_op, 64'hDEADBEEF01234567, 64'h0, 8'h0, 5'h1F, 64'hDEADBEEF01234567);
    @(posedge clock);
    #1;
    chk64("gpr31", 64'hDEADBEEF01234567, PART.gpr_ff[31]);
    done("reg");
  endtask : t_reg

  task automatic t_b2b();
    @(posedge clock);
    req_valid <= 1'b1;
    req       <= '{add_unsigned_op, 64'h5, 64'h7, 8'h0, 64'h0, 64'h0, 5'h01, 5'h02, 5'h03, 5'h1F};
    @(posedge clock);
    req       <= '{load_immediate_op, 64'h0, 64'h0, 8'h2A, 64'h0, 64'h0, 5'h01, 5'h02, 5'h03, 5'h1F};
    #1 chk64("b2b first", 64'hC, wb.data);
    @(posedge clock);
    req_valid <= 1'b0;
    #1 chk64("b2b second", 64'h2A, wb.data);
    @(posedge clock);
    #1 chk64("idle wr_en", 64'h0, {63'h0, wb.wr_en});
    done("b2b");
  endtask : t_b2b

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  initial begin
    repeat (2000) @(posedge clock);
    bad_count++;
    summarize();
  end

  initial begin
    bad_count   = 0;
    comparisons = 0;
    rst_n       = 1'b0;
    req_valid   = 1'b0;
    req         = '0;
    m64         = 1'b0;
    kern        = 1'b0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_word_imm();
    t_modes();
    t_dword_imm();
    t_compare();
    t_reg();
    t_b2b();
    summarize();
  end
endmodule : compact_isa_integer_alu_tb
